// *** psbp_top.sv ***
// parallel slave byte port with AXI4-Lite register access
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module psbp_top #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// device configuration
	input wire logic i_mcu_mode,
	input wire logic [2:0] i_strobe_pin_dir,
	// host strobes and data pins
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_data_pins,
	output logic [7:0] o_data_pins,
	output logic o_data_oe,
	// interrupt
	output logic o_irq,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready
);
	// refuse an address bus too narrow for the register decoder
	if (ADDR_W <= psbp_pkg::DEC_LSB) begin : g_bad_addr_w
		$error("ADDR_W too small");
	end

	psbp_pin_if u_pins ();

	psbp_pin_sync u_sync (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_cs_n(i_cs_n),
		.i_rd_n(i_rd_n),
		.i_wr_n(i_wr_n),
		.i_data(i_data_pins),
		.o_pins(u_pins.src)
	);

	// configuration pins, two stages before use
	logic [3:0] cfg_meta_r;
	logic [3:0] cfg_sync_r;
	logic mcu_mode;
	logic [2:0] strobe_dir;

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			cfg_meta_r <= 4'h0;
			cfg_sync_r <= 4'h0;
		end else begin
			cfg_meta_r <= {i_mcu_mode, i_strobe_pin_dir};
			cfg_sync_r <= cfg_meta_r;
		end
	end

	assign mcu_mode = cfg_sync_r[3];
	assign strobe_dir = cfg_sync_r[2:0];

	// register and port state
	logic sel_r;
	logic sel_nxt;
	logic in_full_r;
	logic in_full_nxt;
	logic out_full_r;
	logic out_full_nxt;
	logic ovf_r;
	logic ovf_nxt;
	logic irq_flag_r;
	logic irq_flag_nxt;
	logic irq_mask_r;
	logic irq_mask_nxt;
	logic irq_out_r;
	logic [7:0] in_byte_r;
	logic [7:0] in_byte_nxt;
	logic [7:0] out_byte_r;
	logic [7:0] out_byte_nxt;
	logic oe_r;
	logic oe_nxt;
	psbp_pkg::psbp_host_e host_r;
	psbp_pkg::psbp_host_e host_nxt;

	// slave port enable
	logic dir_ok;
	logic port_en;
	assign dir_ok = (strobe_dir == psbp_pkg::STROBE_DIR_IN);
	assign port_en = sel_r & mcu_mode & dir_ok;

	// host strobe decode on synchronised pins
	logic wr_low;
	logic rd_low;
	logic host_wr_end;
	logic host_rd_start;
	logic host_rd_end;
	assign wr_low = ~u_pins.cs_n & ~u_pins.wr_n;
	assign rd_low = ~u_pins.cs_n & ~u_pins.rd_n;
	assign host_wr_end = (host_r == psbp_pkg::HOST_WRITE) & ~wr_low;
	assign host_rd_start = (host_r == psbp_pkg::HOST_IDLE) & (host_nxt == psbp_pkg::HOST_READ);
	assign host_rd_end = (host_r == psbp_pkg::HOST_READ) & ~rd_low;

	// host cycle tracker, needs no host clock
	always_comb begin
		host_nxt = host_r;
		case (host_r)
			psbp_pkg::HOST_IDLE: begin
				if (port_en && wr_low) begin
					host_nxt = psbp_pkg::HOST_WRITE;
				end else if (port_en && rd_low) begin
					host_nxt = psbp_pkg::HOST_READ;
				end
			end
			psbp_pkg::HOST_WRITE: begin
				if (!wr_low) begin
					host_nxt = psbp_pkg::HOST_IDLE;
				end
			end
			psbp_pkg::HOST_READ: begin
				if (!rd_low) begin
					host_nxt = psbp_pkg::HOST_IDLE;
				end
			end
			default: begin
				host_nxt = psbp_pkg::HOST_IDLE;
			end
		endcase
	end

	// axi4-lite write channel
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_full_r;
	logic aw_full_nxt;
	logic w_full_r;
	logic w_full_nxt;
	logic awready_r;
	logic awready_nxt;
	logic wready_r;
	logic wready_nxt;
	logic bvalid_r;
	logic bvalid_nxt;
	logic [1:0] bresp_r;
	logic aw_take;
	logic w_take;
	logic wr_fire;
	assign aw_take = i_awvalid & awready_r;
	assign w_take = i_wvalid & wready_r;
	// both halves held: the write lands
	assign wr_fire = aw_full_r & w_full_r;
	assign aw_full_nxt = aw_take | (aw_full_r & ~wr_fire);
	assign w_full_nxt = w_take | (w_full_r & ~wr_fire);
	assign bvalid_nxt = wr_fire | (bvalid_r & ~i_bready);
	// no new write until the response is taken
	assign awready_nxt = ~aw_full_nxt & ~bvalid_nxt;
	assign wready_nxt = ~w_full_nxt & ~bvalid_nxt;

	// write address decode
	logic [3:0] wa_ofs;
	logic wa_hi_zero;
	logic wa_hit_ctrl;
	logic wa_hit_data;
	logic wa_hit_stat;
	logic wa_hit_mask;
	logic wa_ok;
	logic byte0_en;
	logic wr_ctrl;
	logic wr_data;
	logic wr_stat;
	logic wr_mask;
	assign wa_ofs = awaddr_r[psbp_pkg::DEC_LSB-1:0];
	assign wa_hi_zero = (awaddr_r[ADDR_W-1:psbp_pkg::DEC_LSB] == '0);
	assign wa_hit_ctrl = wa_hi_zero & (wa_ofs == psbp_pkg::OFS_CTRL);
	assign wa_hit_data = wa_hi_zero & (wa_ofs == psbp_pkg::OFS_DATA);
	assign wa_hit_stat = wa_hi_zero & (wa_ofs == psbp_pkg::OFS_IRQ_STAT);
	assign wa_hit_mask = wa_hi_zero & (wa_ofs == psbp_pkg::OFS_IRQ_MASK);
	assign wa_ok = wa_hit_ctrl | wa_hit_data | wa_hit_stat | wa_hit_mask;
	assign byte0_en = wr_fire & wstrb_r[0];
	assign wr_ctrl = byte0_en & wa_hit_ctrl;
	assign wr_data = byte0_en & wa_hit_data;
	assign wr_stat = byte0_en & wa_hit_stat;
	assign wr_mask = byte0_en & wa_hit_mask;

	// axi4-lite read channel
	logic arready_r;
	logic arready_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic ar_take;
	logic [3:0] ra_ofs;
	logic ra_hi_zero;
	logic ra_hit_ctrl;
	logic ra_hit_data;
	logic ra_hit_stat;
	logic ra_hit_mask;
	logic ra_ok;
	logic rd_data_hit;
	logic [7:0] ctrl_byte;
	logic [31:0] stat_word;
	logic [31:0] mask_word;
	logic [31:0] rd_word;
	assign ar_take = i_arvalid & arready_r;
	assign rvalid_nxt = ar_take | (rvalid_r & ~i_rready);
	assign arready_nxt = ~rvalid_nxt;
	assign ra_ofs = i_araddr[psbp_pkg::DEC_LSB-1:0];
	assign ra_hi_zero = (i_araddr[ADDR_W-1:psbp_pkg::DEC_LSB] == '0);
	assign ra_hit_ctrl = ra_hi_zero & (ra_ofs == psbp_pkg::OFS_CTRL);
	assign ra_hit_data = ra_hi_zero & (ra_ofs == psbp_pkg::OFS_DATA);
	assign ra_hit_stat = ra_hi_zero & (ra_ofs == psbp_pkg::OFS_IRQ_STAT);
	assign ra_hit_mask = ra_hi_zero & (ra_ofs == psbp_pkg::OFS_IRQ_MASK);
	assign ra_ok = ra_hit_ctrl | ra_hit_data | ra_hit_stat | ra_hit_mask;
	// reading the received byte empties the input buffer
	assign rd_data_hit = ar_take & ra_hit_data;

	// readable words
	always_comb begin
		ctrl_byte = 8'h00;
		ctrl_byte[psbp_pkg::CTRL_IN_FULL_BIT] = in_full_r;
		ctrl_byte[psbp_pkg::CTRL_OUT_FULL_BIT] = out_full_r;
		ctrl_byte[psbp_pkg::CTRL_OVF_BIT] = ovf_r;
		ctrl_byte[psbp_pkg::CTRL_SEL_BIT] = sel_r;
		stat_word = 32'h00000000;
		stat_word[psbp_pkg::IRQ_PORT_BIT] = irq_flag_r;
		mask_word = 32'h00000000;
		mask_word[psbp_pkg::IRQ_PORT_BIT] = irq_mask_r;
	end

	assign rd_word = ra_hit_ctrl ? {24'h000000, ctrl_byte} :
		ra_hit_data ? {24'h000000, in_byte_r} :
		ra_hit_stat ? stat_word :
		ra_hit_mask ? mask_word : 32'h00000000;

	// flag and latch updates, a hardware set wins over a software clear
	assign in_full_nxt = host_wr_end | (in_full_r & ~rd_data_hit);
	assign ovf_nxt = (host_wr_end & in_full_r) |
		(wr_ctrl ? wdata_r[psbp_pkg::CTRL_OVF_BIT] : ovf_r);
	assign sel_nxt = wr_ctrl ? wdata_r[psbp_pkg::CTRL_SEL_BIT] : sel_r;
	// a write during a host read is driven but does not set the flag
	assign out_full_nxt = host_rd_start |
		(wr_data & (host_r != psbp_pkg::HOST_READ)) |
		(out_full_r & ~host_rd_end);
	assign out_byte_nxt = wr_data ? wdata_r[7:0] : out_byte_r;
	assign in_byte_nxt = host_wr_end ? u_pins.data : in_byte_r;
	assign irq_flag_nxt = host_wr_end | host_rd_end |
		(irq_flag_r & ~(wr_stat & wdata_r[psbp_pkg::IRQ_PORT_BIT]));
	assign irq_mask_nxt = wr_mask ? wdata_r[psbp_pkg::IRQ_PORT_BIT] : irq_mask_r;
	assign oe_nxt = (host_nxt == psbp_pkg::HOST_READ) & port_en;

	// host cycle state
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			host_r <= psbp_pkg::HOST_IDLE;
			oe_r <= 1'b0;
		end else begin
			host_r <= host_nxt;
			oe_r <= oe_nxt;
		end
	end

	// flags and byte latches
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			sel_r <= psbp_pkg::CTRL_SEL_RST;
			in_full_r <= psbp_pkg::FLAG_RST;
			out_full_r <= psbp_pkg::FLAG_RST;
			ovf_r <= psbp_pkg::FLAG_RST;
			irq_flag_r <= psbp_pkg::FLAG_RST;
			irq_mask_r <= psbp_pkg::IRQ_MASK_RST;
			irq_out_r <= 1'b0;
			in_byte_r <= psbp_pkg::BYTE_RST;
			out_byte_r <= psbp_pkg::BYTE_RST;
		end else begin
			sel_r <= sel_nxt;
			in_full_r <= in_full_nxt;
			out_full_r <= out_full_nxt;
			ovf_r <= ovf_nxt;
			irq_flag_r <= irq_flag_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_out_r <= irq_flag_r & irq_mask_r;
			in_byte_r <= in_byte_nxt;
			out_byte_r <= out_byte_nxt;
		end
	end

	// write channel registers
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			awaddr_r <= '0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= psbp_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				awaddr_r <= i_awaddr;
			end
			if (w_take) begin
				wdata_r <= i_wdata;
				wstrb_r <= i_wstrb;
			end
			if (wr_fire) begin
				bresp_r <= wa_ok ? psbp_pkg::RESP_OKAY : psbp_pkg::RESP_SLVERR;
			end
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
		end
	end

	// read channel registers
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= psbp_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				rdata_r <= ra_ok ? rd_word : 32'h00000000;
				rresp_r <= ra_ok ? psbp_pkg::RESP_OKAY : psbp_pkg::RESP_SLVERR;
			end
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// outputs straight from flip-flops
	assign o_data_pins = out_byte_r;
	assign o_data_oe = oe_r;
	assign o_irq = irq_out_r;
	assign o_awready = awready_r;
	assign o_wready = wready_r;
	assign o_bresp = bresp_r;
	assign o_bvalid = bvalid_r;
	assign o_arready = arready_r;
	assign o_rdata = rdata_r;
	assign o_rresp = rresp_r;
	assign o_rvalid = rvalid_r;

	// checks on the port behaviour
	property p_oe_only_in_read;
		@(posedge i_core_clk) disable iff (i_srst)
		oe_r |-> (host_r == psbp_pkg::HOST_READ);
	endproperty
	a_oe_only_in_read: assert property (p_oe_only_in_read)
		else $error("data pins driven outside a host read");

	property p_wr_end_flags;
		@(posedge i_core_clk) disable iff (i_srst)
		host_wr_end |=> (in_full_r && irq_flag_r);
	endproperty
	a_wr_end_flags: assert property (p_wr_end_flags)
		else $error("host write end did not set input full and irq");

	property p_ovf_on_full_write;
		@(posedge i_core_clk) disable iff (i_srst)
		(host_wr_end && in_full_r) |=> ovf_r;
	endproperty
	a_ovf_on_full_write: assert property (p_ovf_on_full_write)
		else $error("write into full buffer did not set overflow");

	property p_data_write_drives;
		@(posedge i_core_clk) disable iff (i_srst)
		wr_data |=> (o_data_pins == $past(wdata_r[7:0]));
	endproperty
	a_data_write_drives: assert property (p_data_write_drives)
		else $error("written byte not on the data pins");

	property p_rd_end_flags;
		@(posedge i_core_clk) disable iff (i_srst)
		host_rd_end |=> (!out_full_r && irq_flag_r && !oe_r);
	endproperty
	a_rd_end_flags: assert property (p_rd_end_flags)
		else $error("host read end left output full or pins driven");

	property p_idle_when_off;
		@(posedge i_core_clk) disable iff (i_srst)
		(!port_en && host_r == psbp_pkg::HOST_IDLE) |=> (host_r == psbp_pkg::HOST_IDLE);
	endproperty
	a_idle_when_off: assert property (p_idle_when_off)
		else $error("host cycle started while the port is off");

	property p_irq_follows_flag;
		@(posedge i_core_clk) disable iff (i_srst)
		o_irq == $past(irq_flag_r & irq_mask_r);
	endproperty
	a_irq_follows_flag: assert property (p_irq_follows_flag)
		else $error("interrupt output does not follow masked flag");

	property p_bvalid_held;
		@(posedge i_core_clk) disable iff (i_srst)
		(o_bvalid && !i_bready) |=> o_bvalid;
	endproperty
	a_bvalid_held: assert property (p_bvalid_held)
		else $error("write response dropped before it was taken");
endmodule

// *** psbp_pkg.sv ***
// constants and types of the parallel slave byte port
// Function
// - slave port select turns data latch into host port
// - host reaches port anytime using strobes only
// - port works only in microcontroller configuration
// - write runs while select and write low
// - write end captures byte, sets irq and full
// - read start drives latch, sets output full
// - software write during read drives, no flag
// - read end releases pins and sets irq
// - input full flag reads at bit seven
// - output full flag reads at bit six
// - overflow on write while byte unread, sticky
// - bit four selects port, low nibble zero
package psbp_pkg;
	// register byte offsets, low address nibble
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_DATA = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
	localparam int DEC_LSB = 4;
	// control register field positions
	localparam int CTRL_IN_FULL_BIT = 7;
	localparam int CTRL_OUT_FULL_BIT = 6;
	localparam int CTRL_OVF_BIT = 5;
	localparam int CTRL_SEL_BIT = 4;
	// interrupt status and mask field position
	localparam int IRQ_PORT_BIT = 0;
	// values after reset, and the strobe pin direction that enables the port
	localparam logic CTRL_SEL_RST = 1'b0;
	localparam logic FLAG_RST = 1'b0;
	localparam logic IRQ_MASK_RST = 1'b0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [2:0] STROBE_IDLE = 3'h7;
	localparam logic [2:0] STROBE_DIR_IN = 3'h7;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// host cycle tracker
	typedef enum logic [1:0] {
		HOST_IDLE = 2'b00,
		HOST_WRITE = 2'b01,
		HOST_READ = 2'b10
	} psbp_host_e;
endpackage

// *** psbp_pin_if.sv ***
// synchronised host pins between the pin stage and the port logic
`timescale 1ns/1ps
interface psbp_pin_if;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [7:0] data;
	modport src (output cs_n, output rd_n, output wr_n, output data);
	modport dst (input cs_n, input rd_n, input wr_n, input data);
endinterface

// *** psbp_pin_sync.sv ***
// two-stage synchronisers for the host strobe and data pins
`timescale 1ns/1ps
module psbp_pin_sync (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_srst,
	// raw host pins
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_data,
	// synchronised copy
	psbp_pin_if.src o_pins
);
	localparam int W = 11;
	localparam logic [W-1:0] RST_V = {psbp_pkg::STROBE_IDLE, psbp_pkg::BYTE_RST};
	logic [W-1:0] raw;
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	assign raw = {i_cs_n, i_rd_n, i_wr_n, i_data};
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			// first stage feeds only the second
			always_ff @(posedge i_core_clk) begin
				if (i_srst) begin
					meta_r[g] <= RST_V[g];
					sync_r[g] <= RST_V[g];
				end else begin
					meta_r[g] <= raw[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate
	assign o_pins.cs_n = sync_r[10];
	assign o_pins.rd_n = sync_r[9];
	assign o_pins.wr_n = sync_r[8];
	assign o_pins.data = sync_r[7:0];
endmodule

// *** psbp_host.sv ***
// host model driving the slave port strobes
`timescale 1ns/1ps
module psbp_host (
	input wire logic i_core_clk,
	input wire logic [7:0] i_d,
	input wire logic i_oe,
	output logic o_cs_n = 1,
	output logic o_rd_n = 1,
	output logic o_wr_n = 1,
	output logic [7:0] o_bus
);
	logic [7:0] hd = 0;
	logic he = 0;
	assign o_bus = i_oe ? i_d : he ? hd : ~hd;
	task automatic cyc(input logic w, input logic [7:0] d);
		@(posedge i_core_clk);
		{hd, he, o_wr_n, o_rd_n, o_cs_n} <= {d, w, !w, w, 1'h0};
		repeat (8) @(posedge i_core_clk);
		{o_wr_n, o_rd_n, o_cs_n} <= 3'h7;
		repeat (6) @(posedge i_core_clk);
		he <= 0;
	endtask
endmodule

// *** test_parallel_slave_byte_port.sv ***
// bench of the parallel slave byte port
`timescale 1ns/1ps
module test_parallel_slave_byte_port;
	logic i_core_clk = 0, i_srst = 1, i_cs_n, i_rd_n, i_wr_n, o_data_oe, o_irq, o_awready;
	logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
	logic mcu_mode = 1;
	logic o_wready, o_bvalid, o_arready, o_rvalid;
	logic [7:0] i_awaddr = 0, i_araddr = 0, i_data_pins, o_data_pins, a, b, c;
	logic [31:0] i_wdata = 0, o_rdata;
	logic [1:0] o_bresp, o_rresp;
	logic [33:0] q[$];
	int mismatches = 0, samples_checked = 0, cyc = 0;
	always #5 i_core_clk = ~i_core_clk;
	psbp_top u_dut (.i_core_clk, .i_srst, .i_mcu_mode(mcu_mode), .i_strobe_pin_dir(3'h7), .i_cs_n,
		.i_rd_n, .i_wr_n, .i_data_pins, .o_data_pins, .o_data_oe, .o_irq, .i_awaddr, .i_awvalid,
		.o_awready, .i_wdata, .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
		.i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
	psbp_host h (.i_core_clk, .i_d(o_data_pins), .i_oe(o_data_oe), .o_cs_n(i_cs_n),
		.o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_bus(i_data_pins));
	task automatic chk(input logic [33:0] s, e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge i_core_clk);
		{i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {ad, d, 3'h7};
		fork
			@(posedge i_core_clk iff o_awready) i_awvalid <= 0;
			@(posedge i_core_clk iff o_wready) i_wvalid <= 0;
		join
		@(posedge i_core_clk iff o_bvalid) i_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [33:0] e);
		q.push_back(e);
		@(posedge i_core_clk);
		{i_araddr, i_arvalid, i_rready} <= {ad, 2'h3};
		@(posedge i_core_clk iff o_arready) i_arvalid <= 0;
		@(posedge i_core_clk iff o_rvalid) i_rready <= 0;
	endtask
	always @(posedge i_core_clk) begin
		if (o_rvalid && i_rready) chk({o_rresp, o_rresp ? 32'h0 : o_rdata}, q.pop_front());
		if (++cyc > 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(32'h7e24));
		{a, b, c} = 24'($urandom);
		repeat (6) @(posedge i_core_clk);
		i_srst <= 0;
		rd(0, 0);
		wr(0, 32'h10);
		rd(0, 32'h10);
		wr(8'hC, 1);
		h.cyc(1, a);
		h.cyc(1, b);
		rd(0, 32'hB0);
		rd(8, 1);
		chk(o_irq, 1);
		rd(4, b);
		wr(8, 1);
		wr(0, 32'h10);
		chk(o_irq, 0);
		wr(4, c);
		rd(0, 32'h50);
		fork
			h.cyc(0, 0);
			repeat (8) @(posedge i_core_clk);
		join_any
		chk({o_data_oe, o_data_pins}, {1'h1, c});
		wait fork;
		chk(o_data_oe, 0);
		rd(0, 32'h10);
		rd(8, 1);
		rd(8'h10, 34'h200000000);
		mcu_mode <= 0;
		h.cyc(1, a);
		rd(0, 32'h10);
		tally_and_finish();
	end
endmodule
